/* bench/dio_port_sva.sv */
// checker: bus handshake, outputs and pin polarity of the port
`timescale 1ns/100ps
module dio_port_sva (
  input wire logic             clk,
  input wire logic             rst_b,
  input wire dio_pkg::wb_req_t wb_req,
  input wire logic [31:0]      wb_dat_o,
  input wire logic             wb_ack_o,
  input wire logic [31:0]      in_pin_b,
  input wire logic [31:0]      out_pin_oe,
  input wire logic             irq
);
  logic [8:0] quiet;
  logic [2:0] wrs;
  wire logic  req = wb_req.cyc & wb_req.stb;
  wire logic  rd = wb_ack_o & !wb_req.we;
  // quiet saturates well past the longest filter delay
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      quiet <= 9'h000;
      wrs <= 3'h0;
    end else begin
      quiet <= $stable(in_pin_b) ? quiet + {8'h00, ~&quiet} : 9'h000;
      wrs <= {wrs[1:0], wb_ack_o & wb_req.we};
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_ack_answer: assert property (req & !wb_ack_o |=> wb_ack_o)
    else $error("no ack after request");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_idle: assert property (!req |=> !wb_ack_o)
    else $error("ack without request");
  a_reset_off: assert property (
    $rose(rst_b) |-> ~|out_pin_oe && !irq)
    else $error("outputs not off after reset");
  a_out_write: assert property (
    wb_ack_o & wb_req.we & wb_req.adr == dio_pkg::OFF_OUT
    |-> ##2 out_pin_oe == $past(wb_req.dat, 2))
    else $error("outputs differ from written word");
  a_in_polarity: assert property (
    rd & wb_req.adr == dio_pkg::OFF_IN & quiet == 9'h1ff
    |-> wb_dat_o == ~in_pin_b)
    else $error("input word not inverse of pins");
  a_unmapped_zero: assert property (rd & wb_req.adr == 5'h18 |-> ~|wb_dat_o)
    else $error("unmapped read not zero");
  a_irq_level: assert property (
    $fell(irq) |-> |{wrs, wb_ack_o & wb_req.we})
    else $error("interrupt dropped without a write");
endmodule
bind dio_port dio_port_sva dio_port_sva_inst (.clk, .rst_b, .wb_req,
  .wb_dat_o, .wb_ack_o, .in_pin_b, .out_pin_oe, .irq);

/* bench/dio_port_test.sv */
// testbench: bus, outputs, polarity, filter and edge interrupts
`timescale 1ns/100ps
module dio_port_test;
  logic             clk = 1'b0;
  logic             rst_b = 1'b0;
  logic [31:0]      in_pin_b = 32'hffff_ffff;
  logic [31:0]      rd, out_pin_oe, wb_dat_o;
  logic             wb_ack_o, irq;
  dio_pkg::wb_req_t wb_req;
  int               errors = 0, samples_checked = 0, cycles = 0;
  initial forever #12.5 clk = ~clk;
  dio_port dio_port_inst (.clk, .rst_b, .wb_req, .wb_dat_o, .wb_ack_o,
    .in_pin_b, .out_pin_oe, .irq);
  wb_host wb_host_inst (.clk, .wb_req, .wb_dat_o, .wb_ack_o);
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      errors = errors + 1;
      end_of_test();
    end
  end
  task end_of_test();
    if (errors == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, g);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s: want %h saw %h", n, e, g);
    end
  endtask
  task step(input int n);
    repeat (n) @(posedge clk);
  endtask
  task pin(input logic [31:0] v, input int n);
    in_pin_b <= v;
    step(n);
  endtask
  task wr(input logic [4:0] a, input logic [31:0] d);
    wb_host_inst.xfer(1'b1, a, d, rd);
  endtask
  task rdr(input logic [4:0] a);
    wb_host_inst.xfer(1'b0, a, 32'h0, rd);
  endtask
  task t_output();
    rdr(dio_pkg::OFF_OUT);
    chk("out after reset", 32'h0, rd);
    wr(dio_pkg::OFF_OUT, 32'h8000_0001);
    step(2);
    chk("oe", 32'h8000_0001, out_pin_oe);
  endtask
  task t_reset();
    rst_b <= 1'b0;
    step(2);
    chk("oe in reset", 32'h0, out_pin_oe);
    rst_b <= 1'b1;
    step(3);
    rdr(dio_pkg::OFF_OUT);
    chk("out after mid reset", 32'h0, rd);
    chk("oe after mid reset", 32'h0, out_pin_oe);
  endtask
  task t_input();
    pin(32'h0f0f_00fe, 520);
    rdr(dio_pkg::OFF_IN);
    chk("in", 32'hf0f0_ff01, rd);
    wr(5'h18, 32'hffff_ffff);
    rdr(5'h18);
    chk("unmapped", 32'h0, rd);
  endtask
  task t_irq();
    wr(dio_pkg::OFF_IEDGE, 32'h8000_0000);
    wr(dio_pkg::OFF_IEN, 32'h8000_0003);
    pin(32'h0f0f_00f8, 10);
    chk("irq wrong edge or off", 32'h0, 32'(irq));
    pin(32'h0f0f_00f9, 8);
    chk("irq falling", 32'h1, 32'(irq));
    rdr(dio_pkg::OFF_ISTAT);
    chk("istat", 32'h0000_0001, rd);
    wr(dio_pkg::OFF_ISTAT, 32'hffff_ffff);
    step(3);
    chk("irq cleared", 32'h0, 32'(irq));
    pin(32'h8f0f_00f9, 10);
    chk("irq bit31 wrong edge", 32'h0, 32'(irq));
    pin(32'h0f0f_00f9, 8);
    chk("irq rising", 32'h1, 32'(irq));
    wr(dio_pkg::OFF_IEN, 32'h0);
    step(3);
    chk("irq masked", 32'h0, 32'(irq));
    wr(dio_pkg::OFF_ISTAT, 32'hffff_ffff);
    pin(32'h0f0f_00fb, 10);
    rdr(dio_pkg::OFF_ISTAT);
    chk("istat disabled bit", 32'h0, rd);
    pin(32'h0f0f_00f9, 10);
  endtask
  task t_filter();
    wr(dio_pkg::OFF_FILT, 32'h0000_0010);
    wr(dio_pkg::OFF_IEN, 32'h0000_0001);
    pin(32'h0f0f_00f8, 8);
    pin(32'h0f0f_00f9, 30);
    chk("irq glitch", 32'h0, 32'(irq));
    pin(32'h0f0f_00f8, 30);
    rdr(dio_pkg::OFF_IN);
    chk("in filtered", 32'hf0f0_ff07, rd);
    pin(32'h0f0f_00f9, 30);
    chk("irq after filter", 32'h1, 32'(irq));
  endtask
  initial begin
    step(2);
    rst_b <= 1'b1;
    step(3);
    t_output();
    t_reset();
    t_input();
    t_irq();
    t_filter();
    end_of_test();
  end
endmodule

/* bench/wb_host.sv */
// partner: classic wishbone host, single cycles
`timescale 1ns/100ps
module wb_host (
  input  wire logic        clk,
  output dio_pkg::wb_req_t wb_req,
  input  wire logic [31:0] wb_dat_o,
  input  wire logic        wb_ack_o
);
  initial wb_req = '0;
  task automatic xfer(input logic we, input logic [4:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    wb_req <= '{1'b1, 1'b1, we, 4'hf, a, d};
    @(posedge clk);
    while (wb_ack_o !== 1'b1) @(posedge clk);
    q = wb_dat_o;
    // released lines show inverted leftovers, not the old values
    wb_req <= '{1'b0, 1'b0, ~we, 4'h0, ~a, ~d};
    @(posedge clk);
  endtask
endmodule

/* core/dio_port.sv */
// digital i/o port: 32 filtered inputs with edge interrupts, 32 outputs
`timescale 1ns/100ps
module dio_port (
  input  wire logic                clk,
  input  wire logic                rst_b,
  input  wire dio_pkg::wb_req_t    wb_req,
  output logic [31:0]              wb_dat_o,
  output logic                     wb_ack_o,
  input  wire logic [31:0]         in_pin_b,
  output logic [31:0]              out_pin_oe,
  output logic                     irq
);
  logic        rst_s1;
  logic        rst_sync_b;
  logic [31:0] in_val;
  logic [31:0] in_filt;
  logic [31:0] filt_d;
  logic [31:0] out_reg;
  logic [31:0] ien;
  logic [31:0] iedge;
  logic [31:0] istat;
  logic [7:0]  filt_len;
  logic [31:0] rise;
  logic [31:0] fall;
  logic [31:0] event_hit;
  logic [31:0] clear_mask;
  logic        req;
  logic        wr;
  logic        wr_out;
  logic        wr_ien;
  logic        wr_iedge;
  logic        wr_filt;
  logic        wr_istat;
  logic        rd;
  logic [31:0] wmask;
  logic [31:0] next_out;
  logic [31:0] next_ien;
  logic [31:0] next_iedge;
  logic [31:0] next_rdata;
  genvar       g;

  // reset release through two flops
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1     <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_s1     <= 1'b1;
      rst_sync_b <= rst_s1;
    end
  end

  // bus decode; a write lands at the edge where the host sees ack high
  assign req      = wb_req.cyc & wb_req.stb;
  assign wr       = req & wb_req.we & wb_ack_o;
  assign wr_out   = wr & (wb_req.adr == dio_pkg::OFF_OUT);
  assign wr_ien   = wr & (wb_req.adr == dio_pkg::OFF_IEN);
  assign wr_iedge = wr & (wb_req.adr == dio_pkg::OFF_IEDGE);
  assign wr_filt  = wr & (wb_req.adr == dio_pkg::OFF_FILT) & wb_req.sel[0];
  assign wr_istat = wr & (wb_req.adr == dio_pkg::OFF_ISTAT);
  // read data is fetched one edge early so it stands under ack
  assign rd       = req & ~wb_req.we & ~wb_ack_o;
  assign wmask = {{8{wb_req.sel[3]}}, {8{wb_req.sel[2]}},
                  {8{wb_req.sel[1]}}, {8{wb_req.sel[0]}}};
  assign next_out   = (out_reg & ~wmask) | (wb_req.dat & wmask);
  assign next_ien   = (ien & ~wmask) | (wb_req.dat & wmask);
  assign next_iedge = (iedge & ~wmask) | (wb_req.dat & wmask);
  // clearing honours sel, so a byte write spares the other lanes
  assign clear_mask = wr_istat ? (wb_req.dat & wmask) : dio_pkg::ZERO32;

  // pin low means current flows, so bit reads 1
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      in_val <= dio_pkg::ZERO32;
    end else begin
      in_val <= ~in_pin_b;
    end
  end

  // per-bit filter: a new value must stand filt_len + 1 cycles
  // longer settings trade reaction time for chatter rejection
  generate
    for (g = 0; g < dio_pkg::CH; g++) begin : gen_filt
      logic [7:0] cnt;
      logic       level;
      always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
          cnt   <= dio_pkg::FILT_RESET;
          level <= 1'b0;
        end else if (in_val[g] == level) begin
          cnt <= dio_pkg::FILT_RESET;
        end else if (cnt >= filt_len) begin
          cnt   <= dio_pkg::FILT_RESET;
          level <= in_val[g];
        end else begin
          cnt <= cnt + dio_pkg::ONE8;
        end
      end
      // one writer per flop, the vector only gathers the bits
      assign in_filt[g] = level;
    end
  endgenerate

  // edges come from the filtered value, so glitches shorter than filt_len + 1 cycles never count
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      filt_d <= dio_pkg::ZERO32;
    end else begin
      filt_d <= in_filt;
    end
  end
  assign rise = in_filt & ~filt_d;
  assign fall = ~in_filt & filt_d;
  // iedge 1: bit 0->1 (pin high-to-low); 0: bit 1->0
  assign event_hit = ien
                   & ((iedge & rise) | (~iedge & fall));

  // status sticky; write-one-to-clear, a new event wins
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      istat <= dio_pkg::ZERO32;
    end else begin
      istat <= (istat & ~clear_mask) | event_hit;
    end
  end

  // single level request, only enabled bits count
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      irq <= 1'b0;
    end else begin
      irq <= |(istat & ien);
    end
  end

  // output word stays off until software writes it
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      out_reg <= dio_pkg::ZERO32;
    end else if (wr_out) begin
      out_reg <= next_out;
    end
  end

  // interrupt enables, one per input bit
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      ien <= dio_pkg::ZERO32;
    end else if (wr_ien) begin
      ien <= next_ien;
    end
  end

  // edge selects, one per input bit
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      iedge <= dio_pkg::ZERO32;
    end else if (wr_iedge) begin
      iedge <= next_iedge;
    end
  end

  // filter length lives in the lowest byte lane only
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      filt_len <= dio_pkg::FILT_RESET;
    end else if (wr_filt) begin
      filt_len <= wb_req.dat[7:0];
    end
  end

  // open collector: transistor on (pin pulled low) when bit is 1
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      out_pin_oe <= dio_pkg::ZERO32;
    end else begin
      out_pin_oe <= out_reg;
    end
  end

  // ack one cycle after a request, gone the cycle after;
  // a request still held under ack is not taken twice
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req & ~wb_ack_o;
    end
  end

  // unmapped reads give zero but are still acknowledged
  always_comb begin
    next_rdata = dio_pkg::ZERO32;
    case (wb_req.adr)
      dio_pkg::OFF_IN:    next_rdata = in_filt;
      dio_pkg::OFF_OUT:   next_rdata = out_reg;
      dio_pkg::OFF_IEN:   next_rdata = ien;
      dio_pkg::OFF_IEDGE: next_rdata = iedge;
      dio_pkg::OFF_ISTAT: next_rdata = istat;
      dio_pkg::OFF_FILT:  next_rdata = {24'h00_0000, filt_len};
      default:            next_rdata = dio_pkg::ZERO32;
    endcase
  end

  // read word is registered and holds until the next read
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      wb_dat_o <= dio_pkg::ZERO32;
    end else if (rd) begin
      wb_dat_o <= next_rdata;
    end
  end
endmodule

/* inc/dio_pkg.sv */
// package: register map, reset values and carriers for the digital i/o port
package dio_pkg;
  localparam int          CH          = 32;
  localparam int          AW          = 5;
  localparam logic [4:0]  OFF_IN      = 5'h00;
  localparam logic [4:0]  OFF_OUT     = 5'h04;
  localparam logic [4:0]  OFF_IEN     = 5'h08;
  localparam logic [4:0]  OFF_IEDGE   = 5'h0C;
  localparam logic [4:0]  OFF_ISTAT   = 5'h10;
  localparam logic [4:0]  OFF_FILT    = 5'h14;
  localparam logic [31:0] ZERO32      = 32'h0000_0000;
  localparam logic [7:0]  FILT_RESET  = 8'h00;
  localparam logic [7:0]  ONE8        = 8'h01;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [4:0]  adr;
    logic [31:0] dat;
  } wb_req_t;
endpackage
